// ---- pkg/rpsl_pkg.sv ----
package rpsl_pkg;

  localparam int NUM_PORTS = 2;

  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] PORT_STATUS_BASE = 8'h54;
  localparam logic [7:0] PORT_STATUS_STRIDE = 8'h04;

  // Field positions of the port status word
  localparam int BIT_CONNECT = 0;
  localparam int BIT_ENABLE = 1;
  localparam int BIT_SUSPEND = 2;
  localparam int BIT_RESUME = 3;
  localparam int BIT_OVERCURRENT = 3;
  localparam int BIT_RESET = 4;
  localparam int BIT_CONNECT_CHG = 16;
  localparam int BIT_ENABLE_CHG = 17;
  localparam int BIT_SUSPEND_CHG = 18;
  localparam int BIT_RESET_CHG = 20;

  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_TIME_NS = 1000;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int RESET_TIME_US = 10;
  localparam int RESUME_TIME_US = 20;
  localparam int TIMER_W = 16;

  typedef enum logic [1:0] {
    RPSL_T_IDLE = 2'b00,
    RPSL_T_RUN = 2'b01,
    RPSL_T_DONE = 2'b10
  } rpsl_timer_e;

  function automatic logic [ADDR_W-1:0] rpsl_port_addr(input int port);
    rpsl_port_addr = PORT_STATUS_BASE + ADDR_W'(port) * PORT_STATUS_STRIDE;
  endfunction : rpsl_port_addr

endpackage : rpsl_pkg

// ---- pkg/rpsl_timer_if.sv ----
`timescale 1ns/1ps
interface rpsl_timer_if;
  logic start;
  logic abort;
  logic tick;
  logic busy;
  logic done;

  modport owner (output start, output abort, output tick, input busy, input done);
  modport timer (input start, input abort, input tick, output busy, output done);
endinterface : rpsl_timer_if

// ---- rtl/rpsl_sync.sv ----
`timescale 1ns/1ps
module rpsl_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule : rpsl_sync

// ---- rtl/rpsl_timer.sv ----
`timescale 1ns/1ps
module rpsl_timer
  import rpsl_pkg::*;
#(
  parameter int COUNT = 10
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  rpsl_timer_if.timer tif
);
  localparam logic [TIMER_W-1:0] LAST = TIMER_W'(COUNT - 1);

  rpsl_timer_e state;
  logic [TIMER_W-1:0] ticks;

  // Counts enable ticks; done is a one-cycle pulse
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= RPSL_T_IDLE;
      ticks <= '0;
    end else begin
      case (state)
        RPSL_T_IDLE: begin
          ticks <= '0;
          if (tif.start && !tif.abort) begin
            state <= RPSL_T_RUN;
          end
        end
        RPSL_T_RUN: begin
          if (tif.abort) begin
            state <= RPSL_T_IDLE;
          end else if (tif.tick) begin
            if (ticks == LAST) begin
              state <= RPSL_T_DONE;
            end else begin
              ticks <= ticks + 1'b1;
            end
          end
        end
        RPSL_T_DONE: begin
          state <= RPSL_T_IDLE;
        end
        default: begin
          state <= RPSL_T_IDLE;
        end
      endcase
    end
  end

  assign tif.busy = (state == RPSL_T_RUN);
  assign tif.done = (state == RPSL_T_DONE);
endmodule : rpsl_timer

// ---- rtl/rpsl_top.sv ----
`timescale 1ns/1ps
module rpsl_top
  import rpsl_pkg::*;
#(
  parameter int PORTS = NUM_PORTS,
  parameter int RESET_TICKS = RESET_TIME_US * TICK_TIME_NS / TICK_TIME_NS,
  parameter int RESUME_TICKS = RESUME_TIME_US * TICK_TIME_NS / TICK_TIME_NS
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [31:0] wr_data_i,
  output logic [31:0] rd_data_o,
  input wire logic [PORTS-1:0] connect_pin_i,
  input wire logic [PORTS-1:0] overcurrent_pin_i,
  input wire logic [PORTS-1:0] upstream_resume_pin_i,
  input wire logic [PORTS-1:0] port_power_i,
  input wire logic [PORTS-1:0] bus_error_i,
  input wire logic [PORTS-1:0] nonremovable_mask_i,
  input wire logic controller_resume_state_i,
  output logic [PORTS-1:0] port_enabled_o,
  output logic [PORTS-1:0] port_suspended_o,
  output logic [PORTS-1:0] port_reset_o,
  output logic [PORTS-1:0] port_resume_o,
  output logic [PORTS-1:0] resume_detect_o
);

  localparam logic [TIMER_W-1:0] TICK_LAST = TIMER_W'(TICK_CYCLES - 1);

  // Pin synchronisers
  logic [PORTS-1:0] connect_sync;
  logic [PORTS-1:0] overcurrent_sync;
  logic [PORTS-1:0] resume_sync;

  rpsl_sync #(.WIDTH(3 * PORTS)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i({upstream_resume_pin_i, overcurrent_pin_i, connect_pin_i}),
    .sync_o({resume_sync, overcurrent_sync, connect_sync})
  );

  // Microsecond enable pulse
  logic [TIMER_W-1:0] div_cnt;
  logic tick;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt <= '0;
      tick <= 1'b0;
    end else if (div_cnt == TICK_LAST) begin
      div_cnt <= '0;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 1'b1;
      tick <= 1'b0;
    end
  end

  function automatic logic port_hit(input logic [ADDR_W-1:0] addr, input int port);
    port_hit = (addr == rpsl_port_addr(port));
  endfunction : port_hit

  // Per-port state
  logic [PORTS-1:0] connected;
  logic [PORTS-1:0] connected_prev;
  logic [PORTS-1:0] overcurrent_prev;
  logic [PORTS-1:0] enabled;
  logic [PORTS-1:0] suspended;
  logic [PORTS-1:0] reset_active;
  logic [PORTS-1:0] resuming;
  logic [PORTS-1:0] connect_chg;
  logic [PORTS-1:0] enable_chg;
  logic [PORTS-1:0] suspend_chg;
  logic [PORTS-1:0] reset_chg;
  logic [PORTS-1:0] reset_done;
  logic [PORTS-1:0] resume_done;

  genvar p;
  generate
    for (p = 0; p < PORTS; p++) begin : g_port
      logic wr_hit;
      logic wr_connect;
      logic wr_enable;
      logic wr_suspend;
      logic wr_resume;
      logic wr_reset;
      logic disconnect;
      logic connect_edge;
      logic hw_disable;
      logic upstream_resume;
      logic start_resume;

      rpsl_timer_if reset_tif ();
      rpsl_timer_if resume_tif ();

      rpsl_timer #(.COUNT(RESET_TICKS)) u_reset_timer (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .tif(reset_tif.timer)
      );

      rpsl_timer #(.COUNT(RESUME_TICKS)) u_resume_timer (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .tif(resume_tif.timer)
      );

      assign wr_hit = wr_i && port_hit(addr_i, p);
      assign wr_connect = wr_hit && wr_data_i[BIT_CONNECT];
      assign wr_enable = wr_hit && wr_data_i[BIT_ENABLE];
      assign wr_suspend = wr_hit && wr_data_i[BIT_SUSPEND];
      assign wr_resume = wr_hit && wr_data_i[BIT_RESUME];
      assign wr_reset = wr_hit && wr_data_i[BIT_RESET];

      // Pin or non-removable mask, never a write
      assign connected[p] = connect_sync[p] | nonremovable_mask_i[p];
      assign disconnect = connected_prev[p] && !connected[p];
      assign connect_edge = connected_prev[p] != connected[p];
      assign hw_disable = enabled[p] && (disconnect || (overcurrent_sync[p] && !overcurrent_prev[p])
                          || !port_power_i[p] || bus_error_i[p]);

      assign upstream_resume = suspended[p] && !resuming[p] && resume_sync[p];
      assign start_resume = suspended[p] && !resuming[p] && (wr_resume || resume_sync[p]);

      assign reset_tif.start = wr_reset && connected[p] && !reset_active[p];
      assign reset_tif.abort = disconnect;
      assign reset_tif.tick = tick;
      assign resume_tif.start = start_resume;
      assign resume_tif.abort = disconnect;
      assign resume_tif.tick = tick;

      assign reset_done[p] = reset_tif.done;
      assign resume_done[p] = resume_tif.done;

      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          connected_prev[p] <= 1'b0;
          overcurrent_prev[p] <= 1'b0;
        end else begin
          connected_prev[p] <= connected[p];
          overcurrent_prev[p] <= overcurrent_sync[p];
        end
      end

      // Enabled flag
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          enabled[p] <= 1'b0;
        end else if (hw_disable) begin
          enabled[p] <= 1'b0;
        end else if (reset_done[p] || resume_done[p]) begin
          enabled[p] <= 1'b1;
        end else if (wr_connect) begin
          enabled[p] <= 1'b0;
        end else if (wr_enable && connected[p]) begin
          enabled[p] <= 1'b1;
        end
      end

      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          enable_chg[p] <= 1'b0;
        end else if (hw_disable) begin
          enable_chg[p] <= 1'b1;
        end else if (wr_hit && wr_data_i[BIT_ENABLE_CHG]) begin
          enable_chg[p] <= 1'b0;
        end
      end

      // Suspended flag
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          suspended[p] <= 1'b0;
        end else if (resume_done[p]) begin
          suspended[p] <= 1'b0;
        end else if (reset_done[p] || controller_resume_state_i || disconnect) begin
          suspended[p] <= 1'b0;
        end else if (wr_suspend && connected[p]) begin
          suspended[p] <= 1'b1;
        end
      end

      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          suspend_chg[p] <= 1'b0;
        end else if (resume_done[p]) begin
          suspend_chg[p] <= 1'b1;
        end else if (wr_hit && wr_data_i[BIT_SUSPEND_CHG]) begin
          suspend_chg[p] <= 1'b0;
        end
      end

      // Resume sequence
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          resuming[p] <= 1'b0;
        end else if (resume_done[p] || disconnect || controller_resume_state_i) begin
          resuming[p] <= 1'b0;
        end else if (start_resume) begin
          resuming[p] <= 1'b1;
        end
      end

      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          resume_detect_o[p] <= 1'b0;
        end else begin
          resume_detect_o[p] <= upstream_resume;
        end
      end

      // Port reset
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          reset_active[p] <= 1'b0;
        end else if (reset_done[p] || disconnect) begin
          reset_active[p] <= 1'b0;
        end else if (reset_tif.start) begin
          reset_active[p] <= 1'b1;
        end
      end

      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          reset_chg[p] <= 1'b0;
        end else if (reset_done[p]) begin
          reset_chg[p] <= 1'b1;
        end else if (wr_hit && wr_data_i[BIT_RESET_CHG]) begin
          reset_chg[p] <= 1'b0;
        end
      end

      // Connect change, also flags attempts on an empty port
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          connect_chg[p] <= 1'b0;
        end else if (connect_edge) begin
          connect_chg[p] <= 1'b1;
        end else if (!connected[p] && (wr_enable || wr_suspend || wr_reset)) begin
          connect_chg[p] <= 1'b1;
        end else if (wr_hit && wr_data_i[BIT_CONNECT_CHG]) begin
          connect_chg[p] <= 1'b0;
        end
      end

      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          port_enabled_o[p] <= 1'b0;
          port_suspended_o[p] <= 1'b0;
          port_reset_o[p] <= 1'b0;
          port_resume_o[p] <= 1'b0;
        end else begin
          port_enabled_o[p] <= enabled[p];
          port_suspended_o[p] <= suspended[p];
          port_reset_o[p] <= reset_active[p];
          port_resume_o[p] <= resuming[p];
        end
      end
    end
  endgenerate

  // Read side
  function automatic logic [31:0] status_word(input int port);
    logic [31:0] w;
    w = STATUS_RESET;
    w[BIT_CONNECT] = connected[port];
    w[BIT_ENABLE] = enabled[port];
    w[BIT_SUSPEND] = suspended[port];
    w[BIT_OVERCURRENT] = overcurrent_sync[port];
    w[BIT_RESET] = reset_active[port];
    w[BIT_CONNECT_CHG] = connect_chg[port];
    w[BIT_ENABLE_CHG] = enable_chg[port];
    w[BIT_SUSPEND_CHG] = suspend_chg[port];
    w[BIT_RESET_CHG] = reset_chg[port];
    status_word = w;
  endfunction : status_word

  logic [31:0] next_rd_data;

  always_comb begin
    next_rd_data = STATUS_RESET;
    for (int i = 0; i < PORTS; i++) begin
      if (port_hit(addr_i, i)) begin
        next_rd_data = status_word(i);
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= STATUS_RESET;
    end else if (rd_i) begin
      rd_data_o <= next_rd_data;
    end
  end

endmodule : rpsl_top

// ---- dv/rpsl_usb_dev.sv ----
`timescale 1ns/1ps
module rpsl_usb_dev
  import rpsl_pkg::*;
#(
  parameter int PORTS = NUM_PORTS,
  parameter int WAKE_CYCLES = 30
) (
  input wire logic core_clk_i,
  input wire logic [PORTS-1:0] attach_i,
  input wire logic [PORTS-1:0] wake_i,
  output logic [PORTS-1:0] connect_o,
  output logic [PORTS-1:0] resume_o
);
  int cnt [PORTS] = '{default: 0};
  assign connect_o = attach_i;
  // Resume signalling only from an attached device, then the line is released
  always @(posedge core_clk_i) begin
    for (int p = 0; p < PORTS; p++) begin
      if (wake_i[p] && attach_i[p]) begin
        cnt[p] <= WAKE_CYCLES;
      end else if (cnt[p] > 0) begin
        cnt[p] <= cnt[p] - 1;
      end
    end
  end
  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      resume_o[p] = (cnt[p] > 0) && attach_i[p];
    end
  end
endmodule : rpsl_usb_dev

// ---- dv/rpsl_top_assertions.sv ----
`timescale 1ns/1ps
module rpsl_top_assertions
  import rpsl_pkg::*;
#(
  parameter int PORTS = NUM_PORTS,
  parameter int RESET_TICKS = 10,
  parameter int RESUME_TICKS = 20
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic [31:0] rd_data_o,
  input wire logic [PORTS-1:0] connect_pin_i,
  input wire logic [PORTS-1:0] overcurrent_pin_i,
  input wire logic [PORTS-1:0] upstream_resume_pin_i,
  input wire logic [PORTS-1:0] port_power_i,
  input wire logic [PORTS-1:0] bus_error_i,
  input wire logic [PORTS-1:0] nonremovable_mask_i,
  input wire logic controller_resume_state_i,
  input wire logic [PORTS-1:0] port_enabled_o,
  input wire logic [PORTS-1:0] port_suspended_o,
  input wire logic [PORTS-1:0] port_reset_o,
  input wire logic [PORTS-1:0] port_resume_o,
  input wire logic [PORTS-1:0] resume_detect_o
);
  logic [3:0] up_h;
  logic w0;
  logic ok0;
  assign w0 = wr_i && addr_i == 8'h54 && !controller_resume_state_i;
  assign ok0 = &up_h && port_power_i[0] && !overcurrent_pin_i[0] && !bus_error_i[0];
  // Port 0 presence held long enough to pass the synchronizer
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      up_h <= 4'h0;
    end else begin
      up_h <= {up_h[2:0], connect_pin_i[0] | nonremovable_mask_i[0]};
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_set_suspend: assert property (w0 && wr_data_i == 32'h4 && ok0 |-> ##2 port_suspended_o[0])
    else $error("suspend write did not suspend");
  a_suspend_refused: assert property (w0 && wr_data_i == 32'h4 && up_h == 4'h0 && !nonremovable_mask_i[0]
    |-> ##2 !port_suspended_o[0])
    else $error("unconnected port suspended");
  a_set_enable: assert property (w0 && wr_data_i == 32'h2 && ok0 |-> ##2 port_enabled_o[0])
    else $error("enable write did not enable");
  a_clear_enable: assert property (w0 && wr_data_i == 32'h1 && !port_reset_o[0] && !port_resume_o[0] ##1 !wr_i
    |-> ##1 !port_enabled_o[0])
    else $error("clear enable write left port enabled");
  a_read_connect: assert property (rd_i && addr_i == 8'h54 && &up_h |=> rd_data_o[0])
    else $error("connected port read as absent");
  a_bus_error: assert property (bus_error_i[0] && port_enabled_o[0] |-> ##2 !port_enabled_o[0])
    else $error("bus error left port enabled");
  a_resume_end: assert property ($fell(port_resume_o[0]) && &up_h && !$past(controller_resume_state_i)
    && !$past(controller_resume_state_i, 2) |-> port_enabled_o[0] && !port_suspended_o[0])
    else $error("resume end state wrong");
  a_reset_end: assert property ($fell(port_reset_o[0]) && &up_h |-> port_enabled_o[0] && !port_suspended_o[0])
    else $error("reset end state wrong");
  a_ctrl_resume: assert property (controller_resume_state_i && $past(controller_resume_state_i)
    |=> !port_suspended_o[0])
    else $error("controller resume kept suspend");
  a_resume_pass: assert property (resume_detect_o[0] |-> port_suspended_o[0])
    else $error("resume seen on unsuspended port");
  c_detect: cover property (resume_detect_o[0]);
  c_reset_done: cover property ($fell(port_reset_o[0]));
  c_resume_done: cover property ($fell(port_resume_o[0]));
endmodule : rpsl_top_assertions

bind rpsl_top rpsl_top_assertions #(.PORTS(PORTS), .RESET_TICKS(RESET_TICKS), .RESUME_TICKS(RESUME_TICKS))
  rpsl_top_assertions_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i),
  .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .connect_pin_i(connect_pin_i),
  .overcurrent_pin_i(overcurrent_pin_i), .upstream_resume_pin_i(upstream_resume_pin_i),
  .port_power_i(port_power_i), .bus_error_i(bus_error_i), .nonremovable_mask_i(nonremovable_mask_i),
  .controller_resume_state_i(controller_resume_state_i), .port_enabled_o(port_enabled_o),
  .port_suspended_o(port_suspended_o), .port_reset_o(port_reset_o), .port_resume_o(port_resume_o),
  .resume_detect_o(resume_detect_o));

// ---- dv/rpsl_top_bench.sv ----
`timescale 1ns/1ps
module rpsl_top_bench;
  import rpsl_pkg::*;
  localparam logic [7:0] P0 = 8'h54;
  localparam logic [7:0] P1 = 8'h58;
  logic core_clk_i;
  logic rst_i;
  logic wr_i;
  logic rd_i;
  logic [7:0] addr_i;
  logic [31:0] wr_data_i;
  logic [31:0] rd_data_o;
  logic [1:0] conn;
  logic [1:0] oc;
  logic [1:0] ures;
  logic [1:0] pwr;
  logic [1:0] berr;
  logic [1:0] nonrem;
  logic ctrl_res;
  logic [1:0] attach;
  logic [1:0] wake;
  logic [1:0] en_o;
  logic [1:0] susp_o;
  logic [1:0] rst_o;
  logic [1:0] res_o;
  logic [1:0] det_o;
  int detects = 0;
  int errors = 0;
  int checks_done = 0;

  rpsl_top #(.RESET_TICKS(2), .RESUME_TICKS(2)) rpsl_top_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o),
    .connect_pin_i(conn), .overcurrent_pin_i(oc), .upstream_resume_pin_i(ures), .port_power_i(pwr),
    .bus_error_i(berr), .nonremovable_mask_i(nonrem), .controller_resume_state_i(ctrl_res),
    .port_enabled_o(en_o), .port_suspended_o(susp_o), .port_reset_o(rst_o), .port_resume_o(res_o),
    .resume_detect_o(det_o));
  rpsl_usb_dev rpsl_usb_dev_i (.core_clk_i(core_clk_i), .attach_i(attach), .wake_i(wake),
    .connect_o(conn), .resume_o(ures));

  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  task automatic complete_run;
    if (errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    @(posedge core_clk_i);
    d = rd_data_o;
  endtask : rd

  task automatic chk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    checks_done++;
    if ((d & m) !== e) begin
      errors++;
      $display("unexpected %s exp %h got %h", n, e, d & m);
    end
  endtask : chk

  // Polls until the masked bits drop, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    logic [31:0] d;
    rd(a, d);
    for (int i = 0; i < 100 && (d & m) != 32'h0; i++) begin
      rd(a, d);
    end
  endtask : poll

  // Counts resume detect pulses on port 0
  always @(posedge core_clk_i) begin
    if (det_o[0]) begin
      detects <= detects + 1;
    end
  end

  // Output flags sampled away from the launching edge
  task automatic cmp_pins(input logic [7:0] e, input int ed);
    @(negedge core_clk_i);
    checks_done++;
    if ({en_o, susp_o, rst_o, res_o} !== e || detects != ed) begin
      errors++;
      $display("unexpected pins exp %h %0d got %h %0d", e, ed, {en_o, susp_o, rst_o, res_o}, detects);
    end
  endtask : cmp_pins

  initial begin
    #400000;
    errors++;
    complete_run();
  end

  initial begin
    rst_i = 1'b1;
    {wr_i, rd_i, ctrl_res} = 3'h0;
    addr_i = 8'h00;
    wr_data_i = 32'h0;
    {oc, berr, nonrem, wake} = 8'h00;
    pwr = 2'h3;
    attach = 2'h1;
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    chk("p0", P0, 32'h7, 32'h1);
    chk("p1", P1, 32'h7, 32'h0);
    chk("unmapped", 8'h5c, 32'hffffffff, 32'h0);
    cmp_pins(8'h00, 0);
    wr(P0, 32'h2);
    chk("p0", P0, 32'h7, 32'h3);
    cmp_pins(8'h40, 0);
    chk("p1", P1, 32'h7, 32'h0);
    wr(P1, 32'h2);
    chk("p1", P1, 32'h10007, 32'h10000);
    wr(P0, 32'h0);
    chk("p0", P0, 32'h7, 32'h3);
    wr(P0, 32'h8);
    repeat (120) @(posedge core_clk_i);
    chk("p0", P0, 32'h40007, 32'h3);
    wr(P0, 32'h4);
    chk("p0", P0, 32'h7, 32'h7);
    cmp_pins(8'h50, 0);
    wake <= 2'h1;
    @(posedge core_clk_i);
    wake <= 2'h0;
    poll(P0, 32'h4);
    chk("p0", P0, 32'h40007, 32'h40003);
    cmp_pins(8'h40, 1);
    wr(P0, 32'h40000);
    wr(P0, 32'h4);
    wr(P0, 32'h8);
    @(posedge core_clk_i);
    cmp_pins(8'h51, 1);
    poll(P0, 32'h4);
    chk("p0", P0, 32'h40007, 32'h40003);
    wr(P0, 32'h1);
    chk("p0", P0, 32'h7, 32'h1);
    wr(P0, 32'h4);
    chk("p0", P0, 32'h7, 32'h5);
    wr(P0, 32'h10);
    @(posedge core_clk_i);
    cmp_pins(8'h14, 1);
    poll(P0, 32'h10);
    chk("p0", P0, 32'h100017, 32'h100003);
    cmp_pins(8'h40, 1);
    wr(P0, 32'h4);
    @(posedge core_clk_i);
    ctrl_res <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    ctrl_res <= 1'b0;
    chk("p0", P0, 32'h7, 32'h3);
    berr <= 2'h1;
    @(posedge core_clk_i);
    berr <= 2'h0;
    chk("p0", P0, 32'h20007, 32'h20001);
    wr(P0, 32'h20002);
    oc <= 2'h1;
    repeat (6) @(posedge core_clk_i);
    chk("p0", P0, 32'h20007, 32'h20001);
    oc <= 2'h0;
    wr(P0, 32'h2);
    pwr <= 2'h2;
    repeat (4) @(posedge core_clk_i);
    chk("p0", P0, 32'h7, 32'h1);
    pwr <= 2'h3;
    wr(P0, 32'h20002);
    attach <= 2'h0;
    repeat (6) @(posedge core_clk_i);
    chk("p0", P0, 32'h20007, 32'h20000);
    cmp_pins(8'h00, 1);
    wr(P0, 32'h10000);
    wr(P0, 32'h4);
    chk("p0", P0, 32'h10007, 32'h10000);
    nonrem <= 2'h1;
    repeat (4) @(posedge core_clk_i);
    chk("p0", P0, 32'h7, 32'h1);
    complete_run();
  end
endmodule : rpsl_top_bench
